// ### logic/dbgmc_core.sv
// Purpose: Debug mode control, security gating and debug register file
// Assumes: Serial decoder delivers decoded command strobes on clk
// Notes: Firmware runs on the CPU; this block tracks mode and gates access
// Notes on behaviour
// - Debug entry saves user condition codes; writes change the restored value.
// - Holding and page registers accessible only via debug unit, unsecured.
// - Page enable bit 7 turns on paged addressing for accesses outside debug space.
// - Debug-space hardware commands never do global or paged accesses.
// - Page index bits 3..0 select program page when paging enabled.
// - Eight-bit read-only family identifier at fixed window address.
// - Host commands arrive serially, hardware and firmware classes.
// - Firmware commands reach D, X, Y, SP, PC and exit debug.
// - Hardware commands unless secured outside special single-chip mode; firmware commands need unsecured and active.
// - Secured special reset: check erase, then unsecure, enable, allow all.
// - Failed erase check: enable only, loop; hardware commands only.
// - Secured outside special single-chip mode refuses all debug operation.
// - Not enabled: background command ignored; other activation resumes after delay.
// - Enabled debug activates on command, instruction or breakpoint; special reset active.
// - CPU finishes instruction; breakpoint type selects before or after entry.
// - Active mode maps registers to top window, secure check states also the table; hidden from user up to REG_LAST.
// - Entry from firmware space increments saved PC; host rewrites PC.
// - Status bit 7 is debug enable; clear blocks activation, not hardware commands.
module dbgmc_core
  import dbgmc_pkg::*;
#(
  parameter logic [7:0] FAMILY_IDENTIFIER = FAMILY_IDENTIFIER_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic specialSingleChip,
  input wire logic securedStrap,
  input wire logic eraseCheckDone,
  input wire logic eraseCheckOk,
  input wire logic hwCmdValid,
  input wire logic hwCmdDebugSpace,
  input wire logic hwCmdWrite,
  input wire logic hwCmdBackground,
  input wire logic [ADDR_W-1:0] hwCmdAddr,
  input wire logic [7:0] hwCmdWdata,
  input wire logic fwCmdValid,
  input wire logic fwCmdExit,
  input wire logic cpuBgndInstr,
  input wire logic bkptForce,
  input wire logic bkptTag,
  input wire logic cpuInstrDone,
  input wire logic [7:0] cpuCcr,
  input wire logic [15:0] cpuPc,
  input wire logic cpuPcInFwSpace,
  input wire logic cpuRdValid,
  input wire logic [ADDR_W-1:0] cpuAddr,
  output logic [7:0] hwCmdRdata,
  output logic hwCmdAccepted,
  output logic fwCmdAccepted,
  output logic debugSpaceSel,
  output logic pagedAccess,
  output logic [3:0] pageIndex,
  output logic overlayActive,
  output logic secureTableMapped,
  output logic cpuDebugFetch,
  output logic cpuStall,
  output logic [7:0] ccrRestore,
  output logic [15:0] savedPc,
  output logic userReadBlocked,
  output logic secured,
  output logic debugActive,
  output logic debugEnabled
);
  logic [1:0] strapSync;
  logic ssc;
  logic sec;
  dbgmc_sync #(.WIDTH(2)) uSync (
    .clk(clk),
    .rst_b(rst_b),
    .asyncIn({specialSingleChip, securedStrap}),
    .syncOut(strapSync)
  );
  assign ssc = strapSync[1];
  assign sec = strapSync[0];

  dbgmc_state_e state_r, state_nxt;
  logic enable_r, enable_nxt;
  logic unsecured_flag_r, unsecured_flag_nxt;
  logic [7:0] ccr_r, ccr_nxt;
  logic [7:0] page_r, page_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] dly_r, dly_nxt;
  logic started_r, started_nxt;
  logic bkptAfter_r, bkptAfter_nxt;
  logic [2:0] settle_r, settle_nxt;

  logic isSecured;
  logic hwAllowed;
  logic fwAllowed;
  logic regAccess;
  logic activateReq;

  // Secured unless the strap says open or the unsecure flag was set
  assign isSecured = sec && !unsecured_flag_r;
  assign hwAllowed = !isSecured || ssc;
  assign fwAllowed = !isSecured && (state_r == DM_ACTIVE);
  assign regAccess = hwCmdValid && hwAllowed && hwCmdDebugSpace && !isSecured;
  assign activateReq = (hwCmdValid && hwAllowed && hwCmdBackground) || cpuBgndInstr
                       || bkptForce || bkptTag;

  always_comb begin
    state_nxt = state_r;
    enable_nxt = enable_r;
    unsecured_flag_nxt = unsecured_flag_r;
    ccr_nxt = ccr_r;
    page_nxt = page_r;
    pc_nxt = pc_r;
    rdata_nxt = rdata_r;
    dly_nxt = dly_r;
    started_nxt = started_r;
    settle_nxt = settle_r;
    bkptAfter_nxt = bkptAfter_r;
    if (!started_r) begin
      // Straps are read only once the synchroniser has passed them through
      if (settle_r != 3'(STRAP_SETTLE_CYC)) begin
        settle_nxt = settle_r + 3'h1;
      end else begin
        started_nxt = 1'b1;
        if (ssc) begin
          ccr_nxt = CCR_RST_SSC;
          if (sec) begin
            state_nxt = DM_SEC_CHECK;
          end else begin
            enable_nxt = 1'b1;
            state_nxt = DM_ACTIVE;
          end
        end else begin
          ccr_nxt = CCR_RST_OTHER;
        end
      end
    end else begin
      // Host writes first, so a hardware set or capture in the same cycle wins
      if (regAccess && hwCmdWrite) begin
        case (hwCmdAddr)
          ADDR_STATUS: enable_nxt = hwCmdWdata[ST_ENABLE];
          ADDR_CCR_HOLD: ccr_nxt = hwCmdWdata;
          ADDR_PAGE: page_nxt = hwCmdWdata & PG_MASK;
          default: ;
        endcase
      end
      case (state_r)
        DM_IDLE: begin
          if (activateReq) begin
            if (enable_r && hwAllowed) begin
              bkptAfter_nxt = bkptTag && !bkptForce;
              state_nxt = DM_WAIT_INSTR;
            end else if (!(hwCmdValid && hwCmdBackground)) begin
              dly_nxt = 8'(RESUME_CYC);
              state_nxt = DM_REFUSE;
            end
          end
        end
        DM_WAIT_INSTR: begin
          if (cpuInstrDone) begin
            if (bkptAfter_r) begin
              bkptAfter_nxt = 1'b0;
            end else begin
              ccr_nxt = cpuCcr;
              pc_nxt = cpuPcInFwSpace ? cpuPc + 16'h0001 : cpuPc;
              state_nxt = DM_ACTIVE;
            end
          end
        end
        DM_ACTIVE: begin
          if (fwCmdValid && fwAllowed && fwCmdExit) begin
            state_nxt = DM_IDLE;
          end
        end
        DM_REFUSE: begin
          if (dly_r == 8'h00) begin
            state_nxt = DM_IDLE;
          end else begin
            dly_nxt = dly_r - 8'h01;
          end
        end
        DM_SEC_CHECK: begin
          if (eraseCheckDone) begin
            enable_nxt = 1'b1;
            if (eraseCheckOk) begin
              unsecured_flag_nxt = 1'b1;
              state_nxt = DM_ACTIVE;
            end else begin
              state_nxt = DM_SEC_LOOP;
            end
          end
        end
        DM_SEC_LOOP: begin
          state_nxt = DM_SEC_LOOP;
        end
        default: state_nxt = DM_IDLE;
      endcase
      // Debug register reads
      if (regAccess && !hwCmdWrite) begin
        case (hwCmdAddr)
          ADDR_STATUS: rdata_nxt = {enable_r, state_r == DM_ACTIVE, 4'h0, unsecured_flag_r, 1'b0};
          ADDR_CCR_HOLD: rdata_nxt = ccr_r;
          ADDR_PAGE: rdata_nxt = page_r;
          ADDR_FAMILY: rdata_nxt = FAMILY_IDENTIFIER;
          default: rdata_nxt = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= DM_IDLE;
      enable_r <= 1'b0;
      unsecured_flag_r <= 1'b0;
      ccr_r <= CCR_RST_OTHER;
      page_r <= PAGE_RST;
      pc_r <= 16'h0000;
      rdata_r <= 8'h00;
      dly_r <= 8'h00;
      started_r <= 1'b0;
      bkptAfter_r <= 1'b0;
      settle_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      enable_r <= enable_nxt;
      unsecured_flag_r <= unsecured_flag_nxt;
      ccr_r <= ccr_nxt;
      page_r <= page_nxt;
      pc_r <= pc_nxt;
      rdata_r <= rdata_nxt;
      dly_r <= dly_nxt;
      started_r <= started_nxt;
      bkptAfter_r <= bkptAfter_nxt;
      settle_r <= settle_nxt;
    end
  end

  logic inWindow;
  assign inWindow = (cpuAddr >= WIN_BASE) && (cpuAddr <= WIN_LAST);

  assign hwCmdAccepted = hwCmdValid && hwAllowed;
  assign fwCmdAccepted = fwCmdValid && fwAllowed;
  assign debugSpaceSel = hwCmdValid && hwCmdDebugSpace && hwAllowed;
  // Debug-space commands bypass paging and global mode
  assign pagedAccess = page_r[PG_ENABLE] && !(hwCmdValid && hwCmdDebugSpace);
  assign pageIndex = page_r[PG_IDX_HI:0];
  assign overlayActive = (state_r == DM_ACTIVE) || (state_r == DM_SEC_CHECK)
                         || (state_r == DM_SEC_LOOP);
  assign secureTableMapped = (state_r == DM_SEC_CHECK) || (state_r == DM_SEC_LOOP);
  assign cpuDebugFetch = overlayActive;
  assign cpuStall = 1'b0;
  // User reads up to REG_LAST are blocked outside active mode; the family code above it is not
  assign userReadBlocked = cpuRdValid && (state_r != DM_ACTIVE) && inWindow
                           && (cpuAddr <= REG_LAST);
  assign hwCmdRdata = rdata_r;
  assign ccrRestore = ccr_r;
  assign savedPc = pc_r;
  assign secured = isSecured;
  assign debugActive = (state_r == DM_ACTIVE);
  assign debugEnabled = enable_r;
endmodule

// ### logic/dbgmc_pkg.sv
// Purpose: Shared constants for the debug mode control and security block
// Assumes: 18-bit global address space, byte-wide debug register port
// Notes: Offsets are global addresses of the debug window
package dbgmc_pkg;
  localparam int ADDR_W = 18;
  localparam logic [17:0] WIN_BASE = 18'h3FF00;
  localparam logic [17:0] WIN_LAST = 18'h3FFFF;
  localparam logic [17:0] REG_LAST = 18'h3FF0B;
  localparam logic [17:0] ADDR_STATUS = 18'h3FF01;
  localparam logic [17:0] ADDR_CCR_HOLD = 18'h3FF06;
  localparam logic [17:0] ADDR_PAGE = 18'h3FF07;
  localparam logic [17:0] ADDR_FAMILY = 18'h3FF0F;
  // Status register fields
  localparam int ST_ENABLE = 7;
  localparam int ST_ACTIVE = 6;
  localparam int ST_UNSECURED_FLAG = 1;
  // Page register fields
  localparam int PG_ENABLE = 7;
  localparam int PG_IDX_HI = 3;
  localparam logic [7:0] PG_MASK = 8'h8F;
  // Reset values of the holding and page registers
  localparam logic [7:0] CCR_RST_SSC = 8'hC8;
  localparam logic [7:0] CCR_RST_OTHER = 8'h00;
  localparam logic [7:0] PAGE_RST = 8'h00;
  // Arbitrary neutral family code
  localparam logic [7:0] FAMILY_IDENTIFIER_DEF = 8'h5A;
  // Brief delay before CPU resumes after a refused activation
  localparam int RESUME_DLY_NS = 200;
  localparam int CLK_NS = 40;
  localparam int RESUME_CYC = (RESUME_DLY_NS + CLK_NS - 1) / CLK_NS;
  // Cycles after reset release before the synchronised straps are read
  localparam int STRAP_SETTLE_CYC = 4;
  typedef enum logic [2:0] {
    DM_IDLE = 3'b000,
    DM_WAIT_INSTR = 3'b001,
    DM_ACTIVE = 3'b010,
    DM_REFUSE = 3'b011,
    DM_SEC_CHECK = 3'b100,
    DM_SEC_LOOP = 3'b101
  } dbgmc_state_e;
endpackage

// ### logic/dbgmc_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input asynchronous to clk
// Notes: Output changes once stages two and three agree
module dbgmc_sync
  import dbgmc_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] out_r;
  logic [WIDTH-1:0] out_nxt;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        out_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : out_r[i];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      out_r <= '0;
    end else begin
      s1_r <= asyncIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign syncOut = out_r;
endmodule

// ### tb/dbgmc_assertions.sv
// Purpose: Port checker for the debug mode control core
// Assumes: Straps and CPU capture inputs steady around checked events
// Notes: Bound to every core instance
module dbgmc_assertions
  import dbgmc_pkg::*;
#(
  parameter logic [7:0] FAMILY_IDENTIFIER = FAMILY_IDENTIFIER_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic specialSingleChip,
  input wire logic hwCmdValid,
  input wire logic hwCmdDebugSpace,
  input wire logic hwCmdWrite,
  input wire logic hwCmdBackground,
  input wire logic [ADDR_W-1:0] hwCmdAddr,
  input wire logic [7:0] hwCmdWdata,
  input wire logic fwCmdValid,
  input wire logic fwCmdExit,
  input wire logic [7:0] cpuCcr,
  input wire logic [15:0] cpuPc,
  input wire logic cpuPcInFwSpace,
  input wire logic cpuRdValid,
  input wire logic [ADDR_W-1:0] cpuAddr,
  input wire logic [7:0] hwCmdRdata,
  input wire logic hwCmdAccepted,
  input wire logic fwCmdAccepted,
  input wire logic debugSpaceSel,
  input wire logic pagedAccess,
  input wire logic [3:0] pageIndex,
  input wire logic overlayActive,
  input wire logic secureTableMapped,
  input wire logic userReadBlocked,
  input wire logic [7:0] ccrRestore,
  input wire logic [15:0] savedPc,
  input wire logic secured,
  input wire logic debugActive,
  input wire logic debugEnabled
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence reg_wr(a);
    hwCmdValid && hwCmdAccepted && hwCmdDebugSpace && hwCmdWrite && !secured && hwCmdAddr == a;
  endsequence
  sequence entry_s;
    $rose(debugActive) && !specialSingleChip;
  endsequence
  ccr_write_a: assert property (reg_wr(ADDR_CCR_HOLD) |=> ccrRestore == $past(hwCmdWdata))
    else $error("ccr write lost");
  page_write_a: assert property (reg_wr(ADDR_PAGE) |=> pageIndex == $past(hwCmdWdata[3:0]))
    else $error("page index wrong");
  enable_write_a: assert property (reg_wr(ADDR_STATUS) |=> debugEnabled == $past(hwCmdWdata[7]))
    else $error("enable write lost");
  family_read_a: assert property (hwCmdValid && hwCmdAccepted && hwCmdDebugSpace &&
    !hwCmdWrite && !secured && hwCmdAddr == ADDR_FAMILY |=> hwCmdRdata == FAMILY_IDENTIFIER)
    else $error("family code wrong");
  entry_ccr_a: assert property (entry_s |-> ccrRestore == $past(cpuCcr))
    else $error("ccr not saved");
  entry_pc_a: assert property (entry_s |-> savedPc == $past(cpuPc) + {15'h0000, $past(cpuPcInFwSpace)})
    else $error("saved pc wrong");
  fw_gate_a: assert property (fwCmdAccepted |-> debugActive && !secured)
    else $error("firmware command let through");
  bg_ignore_a: assert property (hwCmdValid && hwCmdBackground && !debugEnabled && !debugActive
    |=> !debugActive [*3])
    else $error("background taken while disabled");
  debug_exit_a: assert property (fwCmdValid && fwCmdExit && debugActive |-> ##[1:2] !debugActive)
    else $error("exit not taken");
  overlay_map_a: assert property (debugActive |-> overlayActive)
    else $error("overlay missing");
  debug_nopage_a: assert property (hwCmdValid && hwCmdDebugSpace |-> !pagedAccess)
    else $error("debug access paged");
  space_select_a: assert property (hwCmdAccepted && hwCmdDebugSpace |-> debugSpaceSel)
    else $error("debug space not selected");
  secure_map_a: assert property (secureTableMapped |-> secured && overlayActive)
    else $error("secure table while open");
  user_hide_a: assert property (cpuRdValid && !debugActive && cpuAddr >= WIN_BASE
    && cpuAddr <= REG_LAST |-> userReadBlocked)
    else $error("user read of debug register");
endmodule

bind dbgmc_core dbgmc_assertions #(.FAMILY_IDENTIFIER(FAMILY_IDENTIFIER)) chk_u (.*);

// ### tb/dbgmc_host.sv
// Purpose: Debug host model issuing decoded commands
// Assumes: A command is taken on the edge after it is raised
// Notes: Released address and data lines show the inverse of their last value
module dbgmc_host (
  input wire logic clk,
  input wire logic hwCmdAccepted,
  input wire logic fwCmdAccepted,
  input wire logic [7:0] hwCmdRdata,
  output logic hwCmdValid,
  output logic hwCmdDebugSpace,
  output logic hwCmdWrite,
  output logic hwCmdBackground,
  output logic [17:0] hwCmdAddr,
  output logic [7:0] hwCmdWdata,
  output logic fwCmdValid,
  output logic fwCmdExit
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {hwCmdValid, hwCmdDebugSpace, hwCmdWrite, hwCmdBackground, fwCmdValid, fwCmdExit} = 6'h00;
    hwCmdAddr = 18'h00000;
    hwCmdWdata = 8'h00;
  end
  task automatic hw(input logic wr, dbg, bg, input logic [17:0] a, input logic [7:0] d,
                    output logic acc, output logic [7:0] rd);
    @(posedge clk);
    {hwCmdValid, hwCmdWrite, hwCmdDebugSpace, hwCmdBackground} <= {1'b1, wr, dbg, bg};
    hwCmdAddr <= a;
    hwCmdWdata <= d;
    #1 acc = hwCmdAccepted;
    @(posedge clk);
    hwCmdValid <= 1'b0;
    hwCmdAddr <= ~a;
    hwCmdWdata <= ~d;
    #1 rd = hwCmdRdata;
  endtask
  task automatic fw(input logic ex, output logic acc);
    @(posedge clk);
    {fwCmdValid, fwCmdExit} <= {1'b1, ex};
    #1 acc = fwCmdAccepted;
    @(posedge clk);
    {fwCmdValid, fwCmdExit} <= 2'h0;
  endtask
endmodule

// ### tb/debug_mode_control_security_tb_top.sv
// Purpose: Self-checking bench for the debug mode control core
// Assumes: Host model drives decoded commands
// Notes: Resets again for each strap case
module debug_mode_control_security_tb_top
  import dbgmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, specialSingleChip = 1'b0, securedStrap = 1'b0;
  logic eraseCheckDone = 1'b0, eraseCheckOk = 1'b0, cpuBgndInstr = 1'b0, bkptForce = 1'b0;
  logic bkptTag = 1'b0, cpuInstrDone = 1'b0, cpuPcInFwSpace = 1'b0, cpuRdValid = 1'b0;
  logic [7:0] cpuCcr = 8'h00;
  logic [15:0] cpuPc = 16'h0000;
  logic [17:0] cpuAddr = 18'h00000, hwCmdAddr;
  logic hwCmdValid, hwCmdDebugSpace, hwCmdWrite, hwCmdBackground, fwCmdValid, fwCmdExit;
  logic hwCmdAccepted, fwCmdAccepted, debugSpaceSel, pagedAccess, overlayActive, cpuStall;
  logic secureTableMapped, cpuDebugFetch, userReadBlocked, secured, debugActive, debugEnabled;
  logic [7:0] hwCmdWdata, hwCmdRdata, ccrRestore, rd;
  logic [3:0] pageIndex;
  logic [15:0] savedPc;
  logic acc;
  int fail_count = 0, num_checks = 0, cycles = 0;
  dbgmc_core dut_u (.*);
  dbgmc_host host_u (.*);
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      give_verdict();
    end
  end
  task chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task give_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task do_reset(input logic ssc, sec);
    @(posedge clk);
    {specialSingleChip, securedStrap, rst_b} <= {ssc, sec, 1'b0};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  // Bits: instruction done, tag, force, halt instruction, erase check done
  task strobe(input logic [4:0] v);
    @(posedge clk);
    {cpuInstrDone, bkptTag, bkptForce, cpuBgndInstr, eraseCheckDone} <= v;
    @(posedge clk);
    {cpuInstrDone, bkptTag, bkptForce, cpuBgndInstr, eraseCheckDone} <= 5'h00;
  endtask
  task t_disabled;
    host_u.hw(1'b0, 1'b0, 1'b1, 18'h00000, 8'h00, acc, rd);
    strobe(5'h04);
    strobe(5'h10);
    repeat (8) @(posedge clk);
    cpuRdValid <= 1'b1;
    cpuAddr <= ADDR_CCR_HOLD;
    @(posedge clk);
    #1;
    chk(debugActive === 1'b0, "active while disabled");
    chk(cpuStall === 1'b0, "cpu stalled");
    chk(userReadBlocked === 1'b1, "user saw debug register");
    host_u.fw(1'b0, acc);
    chk(acc === 1'b0, "firmware taken while inactive");
    $display("t_disabled done");
  endtask
  task t_regs;
    logic [17:0] ra [3];
    logic [7:0] wd [3];
    ra = '{ADDR_CCR_HOLD, ADDR_PAGE, ADDR_PAGE};
    wd = '{8'h3C, 8'h8F, 8'h75};
    for (int i = 0; i < 3; i++) begin
      host_u.hw(1'b1, 1'b1, 1'b0, ra[i], wd[i], acc, rd);
      host_u.hw(1'b0, 1'b1, 1'b0, ra[i], 8'h00, acc, rd);
      chk(rd === (ra[i] == ADDR_PAGE ? wd[i] & PG_MASK : wd[i]), "readback");
      chk(pagedAccess === (i == 1), "paging flag");
    end
    chk(pageIndex === 4'h5, "page index");
    chk(ccrRestore === 8'h3C, "ccr value");
    host_u.hw(1'b1, 1'b1, 1'b0, ADDR_FAMILY, 8'h00, acc, rd);
    host_u.hw(1'b0, 1'b1, 1'b0, ADDR_FAMILY, 8'h00, acc, rd);
    chk(rd === FAMILY_IDENTIFIER_DEF, "family code");
    $display("t_regs done");
  endtask
  task t_activate;
    host_u.hw(1'b1, 1'b1, 1'b0, ADDR_STATUS, 8'h80, acc, rd);
    chk(debugEnabled === 1'b1, "enable flag");
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      cpuCcr <= 8'hA0 + 8'(s);
      cpuPc <= 16'h1230 + 16'(s);
      cpuPcInFwSpace <= s[0];
      if (s == 0) host_u.hw(1'b0, 1'b0, 1'b1, 18'h00000, 8'h00, acc, rd);
      else strobe(5'h01 << s);
      for (int k = 0; k < 3 && debugActive !== 1'b1; k++) begin
        strobe(5'h10);
        @(posedge clk);
        #1;
      end
      chk(debugActive === 1'b1, "not active");
      chk(ccrRestore === 8'hA0 + 8'(s), "saved ccr");
      chk(savedPc === 16'h1230 + 16'(s) + 16'(s[0]), "saved pc");
      chk(overlayActive === 1'b1, "overlay");
      chk(cpuDebugFetch === 1'b1 && userReadBlocked === 1'b0, "firmware view");
      host_u.fw(1'b0, acc);
      chk(acc === 1'b1, "firmware refused");
      host_u.fw(1'b1, acc);
      repeat (2) @(posedge clk);
      #1;
      chk(debugActive === 1'b0, "exit");
    end
    $display("t_activate done");
  endtask
  task t_secure;
    for (int ok = 0; ok < 2; ok++) begin
      do_reset(1'b1, 1'b1);
      eraseCheckOk <= ok[0];
      strobe(5'h01);
      repeat (2) @(posedge clk);
      #1;
      chk(debugEnabled === 1'b1, "enable after check");
      chk(secured === ~ok[0], "secure state");
      host_u.fw(1'b0, acc);
      chk(acc === ok[0], "firmware gating");
      chk(secureTableMapped === ~ok[0], "secure table map");
    end
    do_reset(1'b1, 1'b0);
    #1;
    chk(debugActive === 1'b1 && debugEnabled === 1'b1, "special reset not active");
    chk(ccrRestore === CCR_RST_SSC, "special reset ccr");
    do_reset(1'b0, 1'b1);
    host_u.hw(1'b0, 1'b1, 1'b0, ADDR_CCR_HOLD, 8'h00, acc, rd);
    chk(acc === 1'b0, "secured access taken");
    $display("t_secure done");
  endtask
  initial begin
    do_reset(1'b0, 1'b0);
    t_disabled();
    t_regs();
    t_activate();
    t_secure();
    give_verdict();
  end
endmodule
